// File: rts_map.vh
`ifndef RTS_MAP_VH
`define RTS_MAP_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define RTS_CMD_READ     8'h01
`define RTS_CMD_WRITE    8'h02
`define RTS_CMD_MWRITE   8'h03
`define RTS_CMD_BWRITE   8'h04
`define RTS_CMD_PROT     8'h08
`define RTS_CMD_STOP     8'h13
`define RTS_CMD_OSC_ON   8'h14
`define RTS_CMD_OSC_OFF  8'h15

// ----------------------------------------
// transmission operations
// ----------------------------------------
`define RTS_TX_STRIG     3'h0
`define RTS_TX_SAUTO     3'h1
`define RTS_TX_FTRIG     3'h2
`define RTS_TX_FAUTO     3'h3

// ----------------------------------------
// tag engine operations
// ----------------------------------------
`define RTS_OP_READ      3'h0
`define RTS_OP_WRITE     3'h1
`define RTS_OP_QPROT     3'h2
`define RTS_OP_SPROT     3'h3
`define RTS_OP_HALT      3'h4

// ----------------------------------------
// completion codes
// ----------------------------------------
`define RTS_RC_OK        8'h00
`define RTS_RC_NOTAG     8'h01
`define RTS_RC_PROT      8'h02
`define RTS_RC_ADDR      8'h03
`define RTS_RC_LIMIT     8'h04
`define RTS_RC_COMM      8'h05
`define RTS_RC_STOP      8'h06
`define RTS_RC_MODE      8'h07
`define RTS_RC_CMD       8'h08

// ----------------------------------------
// memory layout and limits
// ----------------------------------------
`define RTS_PAGE_SHIFT   3'h3
`define RTS_SMALL_PAGES  5'h0E
`define RTS_LARGE_PAGES  5'h1E
`define RTS_LIM_CR       5'h10
`define RTS_LIM_CNT      5'h1C
`define RTS_BE_ALL       8'hFF
`define RTS_INIT_CYC     8'h10

`endif

// File: rts_page_pick.v
`include "rts_map.vh"

module rts_page_pick #(
  parameter PG_N = 30
) (
  // page selection
  input  wire [PG_N-1:0] mask,
  // lowest selected page and totals
  output reg  [4:0]      idx,
  output wire            any,
  output reg  [5:0]      count
);

  integer i;

  assign any = |mask;

  // ----------------------------------------
  // lowest set page, page total
  // ----------------------------------------
  always @* begin
    idx   = 5'h00;
    count = 6'h00;
    for (i = PG_N - 1; i >= 0; i = i - 1) begin
      if (mask[i]) begin
        idx   = i[4:0];
        count = count + 6'h01;
      end
    end
  end

endmodule

// File: rts_sequencer.v
// Summary of operation
// (RULE1) each command gets processed, then one response; in S_TWAIT commands other than STOP are dropped unanswered
// (RULE2) stop mode at reset and oscillation-off
// (RULE3) oscillate mode on osc-on or FIFO option
// (RULE4) small tag 112, large 240 user bytes
// (RULE5) eight consecutive bytes make one page
// (RULE6) read: 16 pages CR, 28 count framing
// (RULE7) write: 16 pages CR, 28 count framing
// (RULE8) multiple write has no page limit
// (RULE9) byte write stores selected bytes only
// (RULE10) protected pages readable, never written
// (RULE11) protection changed only by code 08
// (RULE12) host selects transmission operation per command
// (RULE13) single trigger: tag now, respond, wait
// (RULE14) single trigger once; no tag gives error
// (RULE15) single auto waits tag, runs once
// (RULE16) STOP ends single auto tag wait
// (RULE17) FIFO trigger disables tag after processing
// (RULE18) FIFO trigger forces oscillate mode
// (RULE19) green LED while talking to tag
// (RULE20) red LED on unsuccessful completion
// (RULE21) code 14 osc on, 15 osc off
// (RULE22) code 13 is STOP
// (RULE23) init, wait, receive, process, respond, wait
// (RULE24) stop mode: oscillate from start to response
`include "rts_map.vh"

module rts_sequencer #(
  parameter PG_N = 30,
  parameter DW   = 64
) (
  // clock and reset
  input  wire            mclk,
  input  wire            rst_n,
  // host command port
  input  wire            rx_busy,
  input  wire            cmd_valid,
  input  wire [7:0]      cmd_code,
  input  wire [2:0]      cmd_txop,
  input  wire            cmd_cr,
  input  wire [PG_N-1:0] cmd_pages,
  input  wire [7:0]      cmd_bytes,
  input  wire            cmd_wp_set,
  output wire            cmd_ready,
  // host write data
  input  wire [DW-1:0]   wdat_in,
  output reg  [4:0]      wdat_page,
  // response port
  output reg             resp_valid,
  output reg  [7:0]      resp_code,
  input  wire            resp_done,
  output reg             rd_valid,
  output reg  [4:0]      rd_page,
  output reg  [DW-1:0]   rd_data,
  // tag engine
  input  wire            tag_present,
  input  wire            tag_large,
  output reg             tag_req,
  output reg  [2:0]      tag_op,
  output reg  [7:0]      tag_addr,
  output reg  [7:0]      tag_be,
  output reg  [DW-1:0]   tag_wdata,
  input  wire            tag_done,
  input  wire            tag_ok,
  input  wire            tag_wp,
  input  wire [DW-1:0]   tag_rdata,
  // antenna and indicators
  output wire            osc_on,
  output wire            osc_mode,
  output reg             led_green,
  output reg             led_red
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_INIT  = 4'h0;
  localparam S_IDLE  = 4'h1;
  localparam S_RECV  = 4'h2;
  localparam S_DEC   = 4'h3;
  localparam S_TWAIT = 4'h4;
  localparam S_PICK  = 4'h5;
  localparam S_QPROT = 4'h6;
  localparam S_OP    = 4'h7;
  localparam S_HALT  = 4'h8;
  localparam S_RESP  = 4'h9;
  localparam S_TXW   = 4'hA;

  reg  [3:0]      state_reg;
  reg  [3:0]      state_next;
  reg  [7:0]      init_cnt_reg;
  reg  [7:0]      code_reg;
  reg  [2:0]      txop_reg;
  reg             cr_reg;
  reg  [7:0]      bytes_reg;
  reg             wp_set_reg;
  reg  [PG_N-1:0] mask_reg;
  reg  [7:0]      rc_reg;
  reg             osc_mode_reg;
  reg             active_reg;
  reg             tp_meta_reg;
  reg             tp_sync_reg;

  wire [4:0]      pick_idx;
  wire            pick_any;
  wire [5:0]      pick_cnt;
  wire [4:0]      user_pages;
  wire [4:0]      lim;
  wire            is_write;
  wire            is_tagcmd;
  wire            lim_hit;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [PG_N-1:0] page_bit;
    input [4:0] idx;
    begin
      page_bit = {{(PG_N-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  function [7:0] page_addr;
    input [4:0] idx;
    begin
      page_addr = {idx, 3'h0} << (`RTS_PAGE_SHIFT - 3'h3); // RULE5
    end
  endfunction

  // ----------------------------------------
  // tag presence synchroniser
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      tp_meta_reg <= 1'b0;
      tp_sync_reg <= 1'b0;
    end else begin
      tp_meta_reg <= tag_present;
      tp_sync_reg <= tp_meta_reg;
    end
  end

  rts_page_pick #(
    .PG_N (PG_N)
  ) u_pick (
    .mask  (mask_reg),
    .idx   (pick_idx),
    .any   (pick_any),
    .count (pick_cnt)
  );

  // ----------------------------------------
  // decode terms
  // ----------------------------------------
  assign user_pages = tag_large ? `RTS_LARGE_PAGES : `RTS_SMALL_PAGES; // RULE4
  assign lim        = cr_reg ? `RTS_LIM_CR : `RTS_LIM_CNT;
  assign is_write   = (code_reg == `RTS_CMD_WRITE) || (code_reg == `RTS_CMD_MWRITE) ||
                      (code_reg == `RTS_CMD_BWRITE);
  assign is_tagcmd  = is_write || (code_reg == `RTS_CMD_READ) || (code_reg == `RTS_CMD_PROT);
  assign lim_hit    = ((code_reg == `RTS_CMD_READ) || (code_reg == `RTS_CMD_WRITE) ||
                       (code_reg == `RTS_CMD_BWRITE)) && (pick_cnt > {1'b0, lim}); // RULE6 RULE7 RULE8
  assign cmd_ready  = (state_reg == S_IDLE) || (state_reg == S_RECV) || (state_reg == S_TWAIT);
  assign osc_mode   = osc_mode_reg;
  assign osc_on     = osc_mode_reg | active_reg; // RULE24

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_INIT:
        if (init_cnt_reg == `RTS_INIT_CYC)
          state_next = S_IDLE; // RULE23
      S_IDLE:
        if (cmd_valid)
          state_next = S_DEC;
        else if (rx_busy)
          state_next = S_RECV;
      S_RECV:
        if (cmd_valid)
          state_next = S_DEC;
        else if (!rx_busy)
          state_next = S_IDLE;
      S_DEC:
        if (!is_tagcmd || (txop_reg > `RTS_TX_FTRIG))
          state_next = S_RESP;
        else if (lim_hit)
          state_next = S_RESP; // RULE6 RULE7
        else if (txop_reg == `RTS_TX_SAUTO)
          state_next = S_TWAIT; // RULE15
        else if (!tp_sync_reg)
          state_next = S_RESP; // RULE14
        else
          state_next = S_PICK; // RULE13
      S_TWAIT:
        if (cmd_valid && (cmd_code == `RTS_CMD_STOP))
          state_next = S_RESP; // RULE16
        else if (tp_sync_reg)
          state_next = S_PICK;
      S_PICK:
        if (!pick_any)
          state_next = (txop_reg == `RTS_TX_FTRIG) ? S_HALT : S_RESP;
        else if (pick_idx >= user_pages)
          state_next = S_RESP;
        else if (is_write)
          state_next = S_QPROT;
        else
          state_next = S_OP;
      S_QPROT:
        if (tag_done && !tag_ok)
          state_next = S_RESP;
        else if (tag_done && tag_wp)
          state_next = S_PICK; // RULE10
        else if (tag_done)
          state_next = S_OP;
      S_OP:
        if (tag_done && !tag_ok)
          state_next = S_RESP;
        else if (tag_done)
          state_next = S_PICK;
      S_HALT:
        if (tag_done)
          state_next = S_RESP;
      S_RESP: state_next = S_TXW;
      S_TXW:
        if (resp_done)
          state_next = S_IDLE;
      default: state_next = S_INIT;
    endcase
  end

  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg    <= S_INIT;
      init_cnt_reg <= 8'h00;
      code_reg     <= 8'h00;
      txop_reg     <= 3'h0;
      cr_reg       <= 1'b0;
      bytes_reg    <= 8'h00;
      wp_set_reg   <= 1'b0;
      mask_reg     <= {PG_N{1'b0}};
      rc_reg       <= `RTS_RC_OK;
      osc_mode_reg <= 1'b0; // RULE2
      active_reg   <= 1'b0;
      resp_valid   <= 1'b0;
      resp_code    <= `RTS_RC_OK;
      rd_valid     <= 1'b0;
      rd_page      <= 5'h00;
      rd_data      <= {DW{1'b0}};
      wdat_page    <= 5'h00;
      tag_req      <= 1'b0;
      tag_op       <= `RTS_OP_READ;
      tag_addr     <= 8'h00;
      tag_be       <= 8'h00;
      tag_wdata    <= {DW{1'b0}};
      led_green    <= 1'b0;
      led_red      <= 1'b0;
    end else begin
      state_reg  <= state_next;
      tag_req    <= 1'b0;
      resp_valid <= 1'b0;
      rd_valid   <= 1'b0;
      led_green  <= (state_next == S_QPROT) || (state_next == S_OP) || (state_next == S_HALT); // RULE19
      case (state_reg)
        S_INIT: init_cnt_reg <= init_cnt_reg + 8'h01;
        S_IDLE, S_RECV: begin
          if (cmd_valid) begin
            code_reg   <= cmd_code;
            txop_reg   <= cmd_txop; // RULE12
            cr_reg     <= cmd_cr;
            bytes_reg  <= cmd_bytes;
            wp_set_reg <= cmd_wp_set;
            mask_reg   <= cmd_pages;
            rc_reg     <= `RTS_RC_OK;
            led_red    <= 1'b0;
          end
        end
        S_DEC: begin
          if (code_reg == `RTS_CMD_OSC_ON)
            osc_mode_reg <= 1'b1; // RULE21
          else if (code_reg == `RTS_CMD_OSC_OFF)
            osc_mode_reg <= 1'b0; // RULE21
          if (code_reg == `RTS_CMD_STOP)
            rc_reg <= `RTS_RC_OK; // RULE22
          else if (!is_tagcmd && (code_reg != `RTS_CMD_OSC_ON) && (code_reg != `RTS_CMD_OSC_OFF))
            rc_reg <= `RTS_RC_CMD;
          if (is_tagcmd) begin
            if ((txop_reg == `RTS_TX_FTRIG) || (txop_reg == `RTS_TX_FAUTO))
              osc_mode_reg <= 1'b1; // RULE3 RULE18
            if (txop_reg > `RTS_TX_FTRIG)
              rc_reg <= `RTS_RC_MODE;
            else if (lim_hit)
              rc_reg <= `RTS_RC_LIMIT; // RULE6 RULE7 RULE8
            else if (state_next == S_RESP)
              rc_reg <= `RTS_RC_NOTAG; // RULE14
            else
              active_reg <= 1'b1; // RULE24
          end
        end
        S_TWAIT:
          if (state_next == S_RESP)
            rc_reg <= `RTS_RC_STOP; // RULE16
        S_PICK: begin
          tag_addr  <= page_addr(pick_idx); // RULE5
          wdat_page <= pick_idx;
          if (state_next == S_HALT) begin
            tag_req <= 1'b1;
            tag_op  <= `RTS_OP_HALT; // RULE17
          end else if (pick_any && (pick_idx >= user_pages)) begin
            rc_reg <= `RTS_RC_ADDR; // RULE4
          end else if (state_next == S_QPROT) begin
            tag_req <= 1'b1;
            tag_op  <= `RTS_OP_QPROT;
          end else if (state_next == S_OP) begin
            tag_req   <= 1'b1;
            tag_op    <= (code_reg == `RTS_CMD_PROT) ? `RTS_OP_SPROT : `RTS_OP_READ; // RULE11
            tag_be    <= `RTS_BE_ALL;
            tag_wdata <= {{(DW-1){1'b0}}, wp_set_reg};
          end
        end
        S_QPROT: begin
          if (tag_done && !tag_ok) begin
            rc_reg <= `RTS_RC_COMM;
          end else if (tag_done && tag_wp) begin
            rc_reg   <= `RTS_RC_PROT; // RULE10
            mask_reg <= mask_reg & ~page_bit(pick_idx);
          end else if (tag_done) begin
            tag_req   <= 1'b1;
            tag_op    <= `RTS_OP_WRITE;
            tag_wdata <= wdat_in;
            tag_be    <= (code_reg == `RTS_CMD_BWRITE) ? bytes_reg : `RTS_BE_ALL; // RULE9
          end
        end
        S_OP: begin
          if (tag_done && !tag_ok) begin
            rc_reg <= `RTS_RC_COMM;
          end else if (tag_done) begin
            mask_reg <= mask_reg & ~page_bit(pick_idx);
            if (tag_op == `RTS_OP_READ) begin
              rd_valid <= 1'b1;
              rd_page  <= pick_idx;
              rd_data  <= tag_rdata;
            end
          end
        end
        S_HALT:
          if (tag_done && !tag_ok)
            rc_reg <= `RTS_RC_COMM;
        S_RESP: begin
          resp_valid <= 1'b1; // RULE1
          resp_code  <= rc_reg;
          led_red    <= (rc_reg != `RTS_RC_OK); // RULE20
        end
        S_TXW:
          if (resp_done)
            active_reg <= 1'b0; // RULE2 RULE24
        default: rc_reg <= `RTS_RC_OK;
      endcase
    end
  end

endmodule

// File: rts_sequencer_checker.sv
`include "rts_map.vh"
module rts_sequencer_checker (
  // clock and reset
  input wire       mclk,
  input wire       rst_n,
  // host side
  input wire       cmd_valid,
  input wire       cmd_ready,
  input wire [7:0] cmd_code,
  input wire       resp_valid,
  input wire [7:0] resp_code,
  input wire       resp_done,
  // tag side and status
  input wire       tag_req,
  input wire [2:0] tag_op,
  input wire       tag_done,
  input wire       tag_wp,
  input wire       osc_on,
  input wire       osc_mode,
  input wire       led_green,
  input wire       led_red
);
  // ----
  // protocol checks
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire take = cmd_valid && cmd_ready;
  property p_resp_one; resp_valid |=> !resp_valid; endproperty
  a_resp_one: assert property (p_resp_one) else $error("resp_valid held");
  property p_green; tag_req |-> led_green; endproperty
  a_green: assert property (p_green) else $error("green off in tag op");
  property p_red; resp_valid && resp_code != 8'h00 |-> ##[0:1] led_red; endproperty
  a_red: assert property (p_red) else $error("red not lit");
  property p_mode; osc_mode |-> osc_on; endproperty
  a_mode: assert property (p_mode) else $error("osc off in osc mode");
  property p_stop_off; resp_done && !osc_mode |=> !osc_on; endproperty
  a_stop_off: assert property (p_stop_off) else $error("osc on after resp");
  property p_on; take && cmd_code == `RTS_CMD_OSC_ON |-> ##2 osc_mode; endproperty
  a_on: assert property (p_on) else $error("osc on not set");
  property p_off; take && cmd_code == `RTS_CMD_OSC_OFF |-> ##2 !osc_mode; endproperty
  a_off: assert property (p_off) else $error("osc off not set");
  property p_stop; take && cmd_code == `RTS_CMD_STOP |-> ##[1:4] resp_valid; endproperty
  a_stop: assert property (p_stop) else $error("stop not answered");
  property p_wp;
    tag_done && tag_wp && tag_op == `RTS_OP_QPROT |=> !(tag_req && tag_op == `RTS_OP_WRITE);
  endproperty
  a_wp: assert property (p_wp) else $error("write to protected page");
  property p_osc_busy; tag_req |-> osc_on; endproperty
  a_osc_busy: assert property (p_osc_busy) else $error("osc off in tag op");
endmodule
bind rts_sequencer rts_sequencer_checker rts_sequencer_checker_i (.mclk, .rst_n, .cmd_valid,
  .cmd_ready, .cmd_code, .resp_valid, .resp_code, .resp_done, .tag_req, .tag_op, .tag_done,
  .tag_wp, .osc_on, .osc_mode, .led_green, .led_red);

// File: rts_tag_model.sv
`include "rts_map.vh"
module rts_tag_model (
  // control
  input  wire         mclk,
  input  wire         tag_present,
  // request
  input  wire         tag_req,
  input  wire  [2:0]  tag_op,
  input  wire  [7:0]  tag_addr,
  input  wire  [7:0]  tag_be,
  input  wire  [63:0] tag_wdata,
  // answer
  output logic        tag_done,
  output logic        tag_ok,
  output logic        tag_wp,
  output logic [63:0] tag_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // tag memory
  // ----
  logic [7:0]  mem [0:255];
  logic [29:0] prot = '0;
  logic        dead = 0, busy = 0;
  logic [3:0]  wt;
  logic [2:0]  op;
  logic [7:0]  a, be;
  logic [63:0] wd;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    {tag_done, tag_ok, tag_wp, tag_rdata} = '0;
  end
  always @(posedge mclk) begin
    tag_done <= 1'b0;
    {tag_ok, tag_wp, tag_rdata} <= ~{tag_ok, tag_wp, tag_rdata};
    if (!tag_present) dead <= 1'b0;
    if (tag_req) begin
      {busy, op, a, be, wd} <= {1'b1, tag_op, tag_addr, tag_be, tag_wdata};
      wt <= 4'h2 + tag_addr[5:3];
    end else if (busy && wt != 4'h0) begin
      wt <= wt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      tag_done <= 1'b1;
      tag_ok <= tag_present && !dead;
      tag_wp <= prot[a[7:3]];
      if (tag_present && !dead) case (op)
        `RTS_OP_READ: for (int k = 0; k < 8; k++) tag_rdata[8*k+:8] <= mem[a+k];
        `RTS_OP_WRITE: for (int k = 0; k < 8; k++)
          if (be[k] && !prot[a[7:3]]) mem[a+k] <= wd[8*k+:8];
        `RTS_OP_SPROT: prot[a[7:3]] <= |wd;
        `RTS_OP_HALT: dead <= 1'b1;
        default: ;
      endcase
    end
  end
endmodule

// File: rts_sequencer_test.sv
module rts_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // signals
  // ----
  logic        mclk, rst_n, rx_busy, cmd_valid, cmd_cr, cmd_wp_set, resp_done;
  logic        tag_present, tag_large, same;
  logic [7:0]  cmd_code, cmd_bytes;
  logic [2:0]  cmd_txop;
  logic [29:0] cmd_pages;
  logic [63:0] wbase;
  wire  [4:0]  wdat_page, rd_page;
  wire  [63:0] wdat_in = wbase ^ (same ? 64'h0 : {59'h0, wdat_page});
  wire  [7:0]  resp_code, tag_addr, tag_be;
  wire  [2:0]  tag_op;
  wire  [63:0] rd_data, tag_wdata, tag_rdata;
  wire         cmd_ready, resp_valid, rd_valid, tag_req, tag_done, tag_ok, tag_wp;
  wire         osc_on, osc_mode, led_green, led_red;
  int          err_total = 0, n_tests = 0, cyc = 0;
  logic [31:0] seed = 32'h364A;
  logic [7:0]  rmem [0:255];
  logic [29:0] rprot = '0;
  logic        rdead = 0;
  logic [68:0] rdq [$], q;
  rts_sequencer rts_sequencer_i (.mclk, .rst_n, .rx_busy, .cmd_valid, .cmd_code, .cmd_txop,
    .cmd_cr, .cmd_pages, .cmd_bytes, .cmd_wp_set, .cmd_ready, .wdat_in, .wdat_page,
    .resp_valid, .resp_code, .resp_done, .rd_valid, .rd_page, .rd_data, .tag_present,
    .tag_large, .tag_req, .tag_op, .tag_addr, .tag_be, .tag_wdata, .tag_done, .tag_ok,
    .tag_wp, .tag_rdata, .osc_on, .osc_mode, .led_green, .led_red);
  rts_tag_model rts_tag_model_i (.mclk, .tag_present, .tag_req, .tag_op, .tag_addr, .tag_be,
    .tag_wdata, .tag_done, .tag_ok, .tag_wp, .tag_rdata);
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // reference result of one command, memory and read queue updated
  task automatic run(input [7:0] c, input [2:0] op, input cr, input [29:0] pg, input [7:0] be,
                     input ws, input [63:0] d, output logic [7:0] rc);
    logic [63:0] v;
    rc = 8'h00;
    if (c == 8'h13 || c == 8'h14 || c == 8'h15) rc = 8'h00;
    else if (!(c inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h08})) rc = 8'h08;
    else if (op == 3'h3) rc = 8'h07;
    else if (c != 8'h03 && c != 8'h08 && $countones(pg) > (cr ? 16 : 28)) rc = 8'h04;
    else if (!tag_present && op != 3'h1) rc = 8'h01;
    else if (rdead) rc = 8'h05;
    else for (int i = 0; i < 30; i++) if (pg[i] && rc != 8'h03) begin
      v = d ^ (c == 8'h03 ? 64'h0 : 64'(i));
      for (int k = 0; k < 8; k++) v[8*k+:8] = (c == 8'h01) ? rmem[i*8+k] : v[8*k+:8];
      if (i >= (tag_large ? 30 : 14)) rc = 8'h03;
      else if (c == 8'h01) rdq.push_back({5'(i), v});
      else if (c == 8'h08) rprot[i] = ws;
      else if (rprot[i]) rc = 8'h02;
      else for (int k = 0; k < 8; k++) if (c != 8'h04 || be[k]) rmem[i*8+k] = v[8*k+:8];
    end
    if (op == 3'h2 && rc == 8'h00) rdead = 1;
  endtask
  task automatic issue(input [7:0] c, input [2:0] op, input cr, input [29:0] pg, input [7:0] be,
                       input ws);
    @(posedge mclk);
    rx_busy <= 1'b1;
    @(posedge mclk);
    {rx_busy, cmd_valid, cmd_code, cmd_txop, cmd_cr, cmd_pages, cmd_bytes, cmd_wp_set}
      <= {1'b0, 1'b1, c, op, cr, pg, be, ws};
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  task automatic wait_resp(input [7:0] rc);
    int t = 0;
    while (resp_valid !== 1'b1 && t < 3000) begin
      @(posedge mclk);
      t++;
    end
    if (t >= 3000) err_total++;
    chk("resp_code", rc, resp_code);
    repeat (seed[2:0]) @(posedge mclk);
    resp_done <= 1'b1;
    @(posedge mclk);
    resp_done <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cmd(input [7:0] c, input [2:0] op, input cr, input [29:0] pg, input [7:0] be,
                     input late);
    logic [7:0] rc;
    seed = lfsr(seed);
    wbase <= {seed, ~seed};
    same <= (c == 8'h03);
    @(posedge mclk);
    run(c, op, cr, pg, be, seed[31] | (c == 8'h08), {seed, ~seed}, rc);
    issue(c, op, cr, pg, be, seed[31] | (c == 8'h08));
    if (late) begin
      repeat (20) @(posedge mclk);
      tag_present <= 1'b1;
    end
    wait_resp(rc);
  endtask
  // ----
  // clock, timeout, read results
  // ----
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
    if (rd_valid === 1'b1) begin
      q = (rdq.size() > 0) ? rdq.pop_front() : '1;
      chk("rd_page", q[68:64], rd_page);
      chk("rd_data", q[63:0], rd_data);
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {rst_n, rx_busy, cmd_valid, cmd_code, cmd_txop, cmd_cr, cmd_pages} = '0;
    {cmd_bytes, cmd_wp_set, resp_done, same, wbase} = '0;
    {tag_present, tag_large} = 2'b11;
    foreach (rmem[i]) rmem[i] = 8'h00;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("osc_on", 0, osc_on);
    cmd(8'h14, 0, 1, 0, 0, 0);
    chk("osc_mode", 1, osc_mode);
    cmd(8'h15, 0, 1, 0, 0, 0);
    chk("osc_mode", 0, osc_mode);
    cmd(8'h02, 0, 1, {16'h0, seed[13:0]}, 8'hFF, 0);
    cmd(8'h01, 0, 1, 30'h3FFF, 8'hFF, 0);
    cmd(8'h08, 0, 1, 30'h4, 0, 0);
    cmd(8'h02, 0, 1, 30'h5, 8'hFF, 0);
    cmd(8'h04, 0, 1, 30'h7, seed[7:0], 0);
    cmd(8'h01, 0, 1, 30'h7, 0, 0);
    cmd(8'h03, 0, 1, 30'h3FFFFF00, 0, 0);
    cmd(8'h02, 0, 1, 30'h1FFFF, 8'hFF, 0);
    cmd(8'h01, 0, 0, 30'h1FFFFFFF, 0, 0);
    cmd(8'h01, 0, 0, 30'hFFFFFFF, 0, 0);
    tag_large <= 1'b0;
    cmd(8'h01, 0, 1, 30'h6000, 0, 0);
    tag_large <= 1'b1;
    cmd(8'h77, 0, 1, 1, 0, 0);
    cmd(8'h01, 3, 1, 1, 0, 0);
    cmd(8'h15, 0, 1, 0, 0, 0);
    tag_present <= 1'b0;
    cmd(8'h01, 0, 1, 1, 0, 0);
    issue(8'h01, 1, 1, 1, 0, 0);
    repeat (30) @(posedge mclk);
    issue(8'h13, 0, 1, 0, 0, 0);
    wait_resp(8'h06);
    cmd(8'h01, 1, 1, 1, 0, 1);
    cmd(8'h01, 2, 1, 1, 0, 0);
    chk("osc_mode", 1, osc_mode);
    cmd(8'h01, 0, 1, 1, 0, 0);
    end_sim();
  end
endmodule
